// >>> rtl/cip_core.sv
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "cip_cfg.svh"
module cip_core #(
   parameter int NUM_MASK = 12
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic PIN_RESET_IN,
   input wire logic WDT_EXPIRE_IN,
   input wire logic FLASH_KEY_ERR_IN,
   input wire cip_pkg::cip_fetch_s FETCH_IN,
   input wire logic NMI_PIN_IN,
   input wire logic OSC_FAULT_IN,
   input wire logic FLASH_ACC_ERR_IN,
   input wire logic [NUM_MASK-1:0] MASK_REQ_IN,
   input wire logic RETI_IN,
   input wire cip_pkg::cip_reg_op_s REG_OP_IN,
   input wire logic DIGITAL_OSC_USED_IN,
   input wire logic [15:0] MEM_RDATA_IN,
   input wire logic MEM_ACK_IN,
   output cip_pkg::cip_mem_req_s MEM_REQ_OUT,
   output logic [15:0] PC_OUT,
   output logic VECTOR_TAKEN_OUT,
   output logic SYS_RESET_OUT,
   output cip_pkg::cip_gate_s GATE_OUT
);
   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   cip_pkg::cip_state_e state_reg; // sequencer state
   cip_pkg::cip_mem_req_s mem_req_reg; // outstanding memory access
   logic [15:0] rf_reg [16]; // core registers
   logic [15:0] vec_addr_reg; // vector of the request being taken
   logic take_gie_reg; // taken request was maskable
   logic [6:0] flags_reg; // reset and nmi source flags
   logic [2:0] nmi_en_reg; // nmi individual enables
   logic nmi_pin_dly_reg; // nmi pin last level
   cip_pkg::cip_gate_s gate_reg; // registered gates
   cip_pkg::cip_gate_s gate_next;
   logic vec_taken_reg; // handler address loaded
   logic sys_rst_reg; // reset pulse to system
   logic [31:0] hrdata_reg; // bus read data
   logic hready_reg; // bus ready
   logic dp_act_reg; // data phase pending
   logic dp_wr_reg; // data phase is a write
   logic [7:0] dp_addr_reg; // data phase offset
   logic mem_done; // access acknowledged
   logic fetch_illegal; // fetch outside legal memory
   logic rst_evt; // any reset source
   logic nmi_pend; // enabled nmi flag pending
   logic mask_any; // any maskable line
   logic [4:0] mask_prio; // winning maskable priority
   logic idle_ok; // sequencer may accept work
   logic do_reti; // return starts
   logic take_nmi; // nmi taken
   logic take_mask; // maskable taken
   logic op_go; // register op executes
   logic [15:0] op_res; // register op result
   logic [15:0] sp_dec; // stack pointer minus a word
   logic ahb_go; // address phase accepted
   logic sr_wr; // bus writes status word
   logic [2:0] sleep_cur; // current sleep code
   cip_pkg::cip_sleep_e sleep_eff; // sleep code applied to gates

   ////////////////////////////////////////////////////////////////////////////////
   // event decode
   always_comb begin
      // illegal fetch: register space and holes between memories
      fetch_illegal = FETCH_IN.valid &&
         !((FETCH_IN.addr >= `CIP_RAM_LO && FETCH_IN.addr <= `CIP_RAM_HI) ||
           (FETCH_IN.addr >= `CIP_INFO_LO && FETCH_IN.addr <= `CIP_INFO_HI) ||
           (FETCH_IN.addr >= `CIP_CODE_LO));
      // all reset sources funnel into one request
      rst_evt = PIN_RESET_IN | WDT_EXPIRE_IN | FLASH_KEY_ERR_IN | fetch_illegal;
      // nmi: individual enables only, gie not consulted
      nmi_pend = |(flags_reg[6:4] & nmi_en_reg);
      // maskable: only request lines seen, flags live in peripherals
      mask_any = |MASK_REQ_IN;
      mask_prio = `CIP_PRIO_MASK_LO;
      for (int i = 0; i < NUM_MASK; i++) begin
         // higher index overrides, so highest priority wins
         if (MASK_REQ_IN[i]) begin
            mask_prio = `CIP_PRIO_MASK_LO + 5'(i);
         end
      end
      mem_done = mem_req_reg.valid & MEM_ACK_IN;
      idle_ok = (state_reg == cip_pkg::CIP_IDLE) && !mem_req_reg.valid && !rst_evt;
      sleep_cur = rf_reg[`CIP_R_SR][`CIP_SR_SLEEP_HI:`CIP_SR_SLEEP_LO];
      do_reti = idle_ok && RETI_IN && (sleep_cur == cip_pkg::CIP_RUN);
      take_nmi = idle_ok && !do_reti && nmi_pend;
      take_mask = idle_ok && !do_reti && !nmi_pend && mask_any &&
         rf_reg[`CIP_R_SR][`CIP_SR_GIE];
      op_go = idle_ok && !do_reti && !take_nmi && !take_mask && REG_OP_IN.valid &&
         (sleep_cur == cip_pkg::CIP_RUN);
      op_res = REG_OP_IN.add ? rf_reg[REG_OP_IN.dst] + rf_reg[REG_OP_IN.src] : rf_reg[REG_OP_IN.src];
      sp_dec = rf_reg[`CIP_R_SP] - `CIP_WORD_STEP;
      ahb_go = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
      sr_wr = dp_act_reg && dp_wr_reg && (dp_addr_reg == `CIP_OFS_SR);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer and memory port
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         // power-up fetches the reset vector first
         state_reg <= cip_pkg::CIP_RST_VEC;
         mem_req_reg <= '0;
         vec_addr_reg <= `CIP_VEC_RESET;
         take_gie_reg <= 1'b0;
      end else if (rst_evt) begin
         // any reset source aborts work, highest priority
         state_reg <= cip_pkg::CIP_RST_VEC;
         mem_req_reg <= '0;
         vec_addr_reg <= `CIP_VEC_RESET;
      end else if (mem_done) begin
         // access finished, step on
         mem_req_reg.valid <= 1'b0;
         unique case (state_reg)
            cip_pkg::CIP_PUSH_PC: state_reg <= cip_pkg::CIP_PUSH_SR;
            cip_pkg::CIP_PUSH_SR: state_reg <= cip_pkg::CIP_VEC_RD;
            cip_pkg::CIP_POP_SR: state_reg <= cip_pkg::CIP_POP_PC;
            default: state_reg <= cip_pkg::CIP_IDLE;
         endcase
      end else if (!mem_req_reg.valid) begin
         // issue the access of the current state
         unique case (state_reg)
            cip_pkg::CIP_IDLE: begin
               if (do_reti) begin
                  state_reg <= cip_pkg::CIP_POP_SR;
               end else if (take_nmi) begin
                  state_reg <= cip_pkg::CIP_PUSH_PC;
                  vec_addr_reg <= `CIP_VEC_NMI;
                  take_gie_reg <= 1'b0;
               end else if (take_mask) begin
                  // vector = base + 2 * priority, never below slot 16
                  state_reg <= cip_pkg::CIP_PUSH_PC;
                  vec_addr_reg <= `CIP_VEC_BASE + {10'h000, mask_prio, 1'b0};
                  take_gie_reg <= 1'b1;
               end
            end
            cip_pkg::CIP_PUSH_PC: begin
               mem_req_reg <= '{valid: 1'b1, write: 1'b1, addr: sp_dec, wdata: rf_reg[`CIP_R_PC]};
            end
            cip_pkg::CIP_PUSH_SR: begin
               mem_req_reg <= '{valid: 1'b1, write: 1'b1, addr: sp_dec, wdata: rf_reg[`CIP_R_SR]};
            end
            cip_pkg::CIP_POP_SR, cip_pkg::CIP_POP_PC: begin
               mem_req_reg <= '{valid: 1'b1, write: 1'b0, addr: rf_reg[`CIP_R_SP], wdata: 16'h0000};
            end
            cip_pkg::CIP_VEC_RD, cip_pkg::CIP_RST_VEC: begin
               mem_req_reg <= '{valid: 1'b1, write: 1'b0, addr: vec_addr_reg, wdata: 16'h0000};
            end
            default: state_reg <= cip_pkg::CIP_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // core registers: r0 pc, r1 sp, r2 sr, r3 constant zero
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < 16; i++) begin
            rf_reg[i] <= 16'h0000;
         end
         rf_reg[`CIP_R_SP] <= `CIP_SP_RST;
      end else if (rst_evt) begin
         // reset restores status and stack
         rf_reg[`CIP_R_SR] <= `CIP_SR_RST;
         rf_reg[`CIP_R_SP] <= `CIP_SP_RST;
      end else if (mem_done) begin
         unique case (state_reg)
            cip_pkg::CIP_PUSH_PC: rf_reg[`CIP_R_SP] <= sp_dec;
            cip_pkg::CIP_PUSH_SR: begin
               // wake: clear sleep code and gie, for nmi and maskable requests alike
               rf_reg[`CIP_R_SP] <= sp_dec;
               rf_reg[`CIP_R_SR][`CIP_SR_SLEEP_HI:`CIP_SR_SLEEP_LO] <= cip_pkg::CIP_RUN;
               rf_reg[`CIP_R_SR][`CIP_SR_GIE] <= 1'b0;
            end
            cip_pkg::CIP_VEC_RD: rf_reg[`CIP_R_PC] <= MEM_RDATA_IN;
            cip_pkg::CIP_POP_SR: begin
               // popped status brings back the prior sleep level
               rf_reg[`CIP_R_SR] <= MEM_RDATA_IN;
               rf_reg[`CIP_R_SP] <= rf_reg[`CIP_R_SP] + `CIP_WORD_STEP;
            end
            cip_pkg::CIP_POP_PC: begin
               rf_reg[`CIP_R_PC] <= MEM_RDATA_IN;
               rf_reg[`CIP_R_SP] <= rf_reg[`CIP_R_SP] + `CIP_WORD_STEP;
            end
            cip_pkg::CIP_RST_VEC: begin
               if (MEM_RDATA_IN == `CIP_ERASED_WORD) begin
                  // erased memory: go straight to deepest sleep
                  rf_reg[`CIP_R_SR][`CIP_SR_SLEEP_HI:`CIP_SR_SLEEP_LO] <= cip_pkg::CIP_SLEEP4;
               end else begin
                  rf_reg[`CIP_R_PC] <= MEM_RDATA_IN;
               end
            end
            default: rf_reg[`CIP_R_PC] <= rf_reg[`CIP_R_PC];
         endcase
      end else begin
         // bus write and register op may share a cycle, neither is dropped; the op wins on the same word
         if (sr_wr) begin
            // software writes the status word over the bus
            rf_reg[`CIP_R_SR] <= HWDATA_IN[15:0];
         end
         if (op_go && REG_OP_IN.dst != `CIP_R_CG) begin
            // single-cycle register operation, constant register is read-only
            rf_reg[REG_OP_IN.dst] <= op_res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // source flags and nmi enables
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         flags_reg <= `CIP_FLAGS_RST;
         nmi_en_reg <= `CIP_NMI_EN_RST;
         nmi_pin_dly_reg <= 1'b0;
      end else begin
         nmi_pin_dly_reg <= NMI_PIN_IN;
         // write-one-to-clear first, set events override it
         if (dp_act_reg && dp_wr_reg && dp_addr_reg == `CIP_OFS_FLAGS) begin
            flags_reg <= (flags_reg & ~HWDATA_IN[6:0]) |
               {FLASH_ACC_ERR_IN, OSC_FAULT_IN, NMI_PIN_IN & ~nmi_pin_dly_reg,
                FLASH_KEY_ERR_IN, WDT_EXPIRE_IN, PIN_RESET_IN, 1'b0};
         end else begin
            flags_reg <= flags_reg |
               {FLASH_ACC_ERR_IN, OSC_FAULT_IN, NMI_PIN_IN & ~nmi_pin_dly_reg,
                FLASH_KEY_ERR_IN, WDT_EXPIRE_IN, PIN_RESET_IN, 1'b0};
         end
         if (rst_evt) begin
            nmi_en_reg <= `CIP_NMI_EN_RST;
         end else if (take_nmi) begin
            // taking an nmi drops its enables against re-entry
            nmi_en_reg <= `CIP_NMI_EN_RST;
         end else if (dp_act_reg && dp_wr_reg && dp_addr_reg == `CIP_OFS_NMI_EN) begin
            nmi_en_reg <= HWDATA_IN[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // clock and power gating from the sleep code
   always_comb begin
      // any sequence in progress runs at full power
      sleep_eff = (state_reg == cip_pkg::CIP_IDLE) ? cip_pkg::cip_sleep_e'(sleep_cur) : cip_pkg::CIP_RUN;
      gate_next = '{cpu_run: 1'b1, mclk_en: 1'b1, sub_clk_en: 1'b1, aux_clk_en: 1'b1,
                    osc_bias_en: 1'b1, xtal_en: 1'b1};
      unique case (sleep_eff)
         cip_pkg::CIP_SLEEP0: begin
            gate_next.cpu_run = 1'b0;
            gate_next.mclk_en = 1'b0;
         end
         cip_pkg::CIP_SLEEP1: begin
            gate_next.cpu_run = 1'b0;
            gate_next.mclk_en = 1'b0;
            gate_next.osc_bias_en = DIGITAL_OSC_USED_IN;
         end
         cip_pkg::CIP_SLEEP2: begin
            gate_next.cpu_run = 1'b0;
            gate_next.mclk_en = 1'b0;
            gate_next.sub_clk_en = 1'b0;
         end
         cip_pkg::CIP_SLEEP3: begin
            gate_next.cpu_run = 1'b0;
            gate_next.mclk_en = 1'b0;
            gate_next.sub_clk_en = 1'b0;
            gate_next.osc_bias_en = 1'b0;
         end
         cip_pkg::CIP_SLEEP4: begin
            gate_next = '0;
         end
         cip_pkg::CIP_RUN: gate_next.cpu_run = 1'b1;
         default: gate_next = '0;
      endcase
   end

   // gates and status pulses registered
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         gate_reg <= '0;
         vec_taken_reg <= 1'b0;
         sys_rst_reg <= 1'b0;
      end else begin
         gate_reg <= gate_next;
         vec_taken_reg <= mem_done && !rst_evt && (state_reg == cip_pkg::CIP_VEC_RD);
         sys_rst_reg <= rst_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: writes zero-wait, reads one wait state
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         dp_act_reg <= 1'b0;
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hready_reg <= 1'b1;
         hrdata_reg <= 32'h0000_0000;
      end else if (!hready_reg) begin
         // read data phase: fetch register, then release
         hready_reg <= 1'b1;
         dp_act_reg <= 1'b0;
         unique case (dp_addr_reg)
            `CIP_OFS_SR: hrdata_reg <= {16'h0000, rf_reg[`CIP_R_SR]};
            `CIP_OFS_NMI_EN: hrdata_reg <= {29'h0000_0000, nmi_en_reg};
            `CIP_OFS_FLAGS: hrdata_reg <= {25'h000_0000, flags_reg};
            `CIP_OFS_STATE: hrdata_reg <= {9'h000, sleep_cur, 1'b0, state_reg, rf_reg[`CIP_R_PC]};
            default: hrdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         dp_act_reg <= ahb_go;
         dp_wr_reg <= HWRITE_IN;
         dp_addr_reg <= HADDR_IN[7:0];
         if (ahb_go && !HWRITE_IN) begin
            hready_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign HRDATA_OUT = hrdata_reg;
   assign HREADYOUT_OUT = hready_reg;
   assign HRESP_OUT = 1'b0;
   assign MEM_REQ_OUT = mem_req_reg;
   assign PC_OUT = rf_reg[`CIP_R_PC];
   assign VECTOR_TAKEN_OUT = vec_taken_reg;
   assign SYS_RESET_OUT = sys_rst_reg;
   assign GATE_OUT = gate_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   vec_window_a: assert property (mem_req_reg.valid && state_reg == cip_pkg::CIP_VEC_RD |->
      mem_req_reg.addr >= `CIP_VEC_LOWEST_USED) else $error("vector below used slots");
   vec_load_a: assert property (mem_done && !rst_evt && state_reg == cip_pkg::CIP_VEC_RD |=>
      PC_OUT == $past(MEM_RDATA_IN) && VECTOR_TAKEN_OUT) else $error("handler address not loaded");
   erased_sleep_a: assert property (mem_done && !rst_evt && state_reg == cip_pkg::CIP_RST_VEC &&
      MEM_RDATA_IN == `CIP_ERASED_WORD |=> sleep_cur == cip_pkg::CIP_SLEEP4 ##1 GATE_OUT == '0)
      else $error("erased vector did not sleep");
   reset_first_a: assert property (rst_evt |=> state_reg == cip_pkg::CIP_RST_VEC && SYS_RESET_OUT)
      else $error("reset source not served");
   nmi_no_gie_a: assert property (take_nmi |=> state_reg == cip_pkg::CIP_PUSH_PC &&
      vec_addr_reg == `CIP_VEC_NMI) else $error("nmi not taken to its vector");
   mask_gie_a: assert property (idle_ok && mask_any && !nmi_pend && !RETI_IN &&
      !rf_reg[`CIP_R_SR][`CIP_SR_GIE] |=> state_reg == cip_pkg::CIP_IDLE)
      else $error("maskable taken with gie clear");
   port_prio_a: assert property (take_mask && MASK_REQ_IN[1] && !(|MASK_REQ_IN[NUM_MASK-1:2]) |=>
      vec_addr_reg == `CIP_VEC_BASE + {10'h000, `CIP_PRIO_PORT_B, 1'b0})
      else $error("wrong port vector");
   fetch_reset_a: assert property (FETCH_IN.valid && FETCH_IN.addr <= `CIP_PERIPH_HI |=> SYS_RESET_OUT)
      else $error("illegal fetch not reset");
   wake_restore_a: assert property (mem_done && !rst_evt && state_reg == cip_pkg::CIP_POP_SR |=>
      rf_reg[`CIP_R_SR] == $past(MEM_RDATA_IN)) else $error("status word not restored");
   sleep_level_0_gate_a: assert property (state_reg == cip_pkg::CIP_IDLE && sleep_cur == cip_pkg::CIP_SLEEP0 |=>
      !GATE_OUT.cpu_run && !GATE_OUT.mclk_en && GATE_OUT.sub_clk_en && GATE_OUT.aux_clk_en)
      else $error("sleep level 0 gates wrong");
   sleep_level_3_gate_a: assert property (state_reg == cip_pkg::CIP_IDLE && sleep_cur == cip_pkg::CIP_SLEEP3 |=>
      GATE_OUT.aux_clk_en && !GATE_OUT.sub_clk_en && !GATE_OUT.osc_bias_en)
      else $error("sleep level 3 gates wrong");
   reg_op_a: assert property (op_go && REG_OP_IN.dst > `CIP_R_CG |=> rf_reg[$past(REG_OP_IN.dst)] ==
      $past(op_res)) else $error("register op not done in one cycle");

   take_nmi_c: cover property (take_nmi ##[1:40] VECTOR_TAKEN_OUT);
   wake_c: cover property (sleep_cur == cip_pkg::CIP_SLEEP3 && take_mask ##[1:80] do_reti);
   erased_c: cover property (state_reg == cip_pkg::CIP_RST_VEC && mem_done && MEM_RDATA_IN == `CIP_ERASED_WORD);
endmodule : cip_core

// >>> rtl/cip_cfg.svh
`ifndef CIP_CFG_SVH
`define CIP_CFG_SVH
// vector table
`define CIP_VEC_BASE 16'hFFC0
`define CIP_VEC_RESET 16'hFFFE
`define CIP_VEC_NMI 16'hFFFC
`define CIP_VEC_LOWEST_USED 16'hFFE0
`define CIP_PRIO_MASK_LO 5'h12
`define CIP_PRIO_PORT_B 5'h13
`define CIP_PRIO_PORT_A 5'h12
`define CIP_ERASED_WORD 16'hFFFF
// fetch-legal address ranges
`define CIP_PERIPH_HI 16'h01FF
`define CIP_RAM_LO 16'h0200
`define CIP_RAM_HI 16'h027F
`define CIP_INFO_LO 16'h1000
`define CIP_INFO_HI 16'h10FF
`define CIP_CODE_LO 16'hF800
// core register indexes and fields
`define CIP_R_PC 4'h0
`define CIP_R_SP 4'h1
`define CIP_R_SR 4'h2
`define CIP_R_CG 4'h3
`define CIP_SR_GIE 3
`define CIP_SR_SLEEP_HI 6
`define CIP_SR_SLEEP_LO 4
`define CIP_SR_RST 16'h0000
`define CIP_SP_RST 16'h0280
`define CIP_WORD_STEP 16'h0002
// flags: 0 power_on 1 pin_reset 2 watchdog 3 flash_key 4 nmi_pin 5 osc_fault 6 flash_access
`define CIP_FLAGS_RST 7'h01
`define CIP_NMI_EN_RST 3'h0
// bus register offsets
`define CIP_OFS_SR 8'h00
`define CIP_OFS_NMI_EN 8'h04
`define CIP_OFS_FLAGS 8'h08
`define CIP_OFS_STATE 8'h0C
`endif

// >>> rtl/cip_pkg.sv
package cip_pkg;
   // sequencer states, gray along take path
   typedef enum logic [2:0] {
      CIP_IDLE = 3'h0,
      CIP_PUSH_PC = 3'h1,
      CIP_PUSH_SR = 3'h3,
      CIP_VEC_RD = 3'h2,
      CIP_POP_SR = 3'h4,
      CIP_POP_PC = 3'h5,
      CIP_RST_VEC = 3'h6
   } cip_state_e;
   // sleep code held in the status word
   typedef enum logic [2:0] {
      CIP_RUN = 3'h0,
      CIP_SLEEP0 = 3'h1,
      CIP_SLEEP1 = 3'h2,
      CIP_SLEEP2 = 3'h3,
      CIP_SLEEP3 = 3'h4,
      CIP_SLEEP4 = 3'h5
   } cip_sleep_e;
   // memory request toward program/data memory
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } cip_mem_req_s;
   // instruction fetch observed for range checking
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } cip_fetch_s;
   // register-to-register operation
   typedef struct packed {
      logic valid;
      logic add;
      logic [3:0] src;
      logic [3:0] dst;
   } cip_reg_op_s;
   // clock and power gates toward the clock module
   typedef struct packed {
      logic cpu_run;
      logic mclk_en;
      logic sub_clk_en;
      logic aux_clk_en;
      logic osc_bias_en;
      logic xtal_en;
   } cip_gate_s;
endpackage : cip_pkg

// >>> testbench/cip_mem_model.sv
`timescale 1ns/100ps
// program memory: vector slot xx holds handler F8xx, stack words kept
module cip_mem_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire cip_pkg::cip_mem_req_s req_in,
   input wire logic erase_in,
   output logic [15:0] rdata_out,
   output logic ack_out
);
   logic [15:0] mem [128]; // words pushed by the core, by word index of the low memory
   logic slow_reg; // alternates prompt and slow answers
   logic [1:0] wait_reg; // slow answer delay
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {ack_out, slow_reg, wait_reg, rdata_out} <= '0;
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out; // no stale word outside an answer
         if (req_in.valid && !ack_out) begin
            if (slow_reg && wait_reg != 2'h3) begin
               wait_reg <= wait_reg + 2'h1;
            end else begin
               {wait_reg, ack_out} <= 3'h1;
               slow_reg <= !slow_reg;
               if (req_in.write) begin
                  mem[req_in.addr[7:1]] <= req_in.wdata;
               end else if (req_in.addr >= 16'hF800) begin
                  // erased part: the reset vector reads all ones
                  rdata_out <= (erase_in && req_in.addr == 16'hFFFE) ? 16'hFFFF : {8'hF8, req_in.addr[7:0]};
               end else begin
                  rdata_out <= mem[req_in.addr[7:1]];
               end
            end
         end
      end
   end
endmodule : cip_mem_model

// >>> testbench/test_cpu_interrupt_power_control.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_cpu_interrupt_power_control;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, reti = 0, osc = 0, nmi = 0, oscf = 0, acc = 0, erase = 0;
   logic hrdy, tk, srst, ack, hs, hresp;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, hd, rd;
   logic [2:0] rsrc = 0; // pin, watchdog, key
   logic [11:0] req = 0;
   logic [15:0] pc, mrd;
   cip_pkg::cip_fetch_s fetch = '0;
   cip_pkg::cip_reg_op_s rop = '0;
   cip_pkg::cip_mem_req_s mreq;
   cip_pkg::cip_gate_s gate;
   int bad_count = 0, num_checks = 0, cyc = 0;
   logic [5:0] gtab [6] = '{6'h3F, 6'h0F, 6'h0D, 6'h07, 6'h05, 6'h00}; // run, sleep levels 0..4
   cip_core dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HRDATA_OUT(hrdata),
      .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .PIN_RESET_IN(rsrc[0]), .WDT_EXPIRE_IN(rsrc[1]),
      .FLASH_KEY_ERR_IN(rsrc[2]), .FETCH_IN(fetch), .NMI_PIN_IN(nmi), .OSC_FAULT_IN(oscf),
      .FLASH_ACC_ERR_IN(acc), .MASK_REQ_IN(req), .RETI_IN(reti), .REG_OP_IN(rop), .DIGITAL_OSC_USED_IN(osc),
      .MEM_RDATA_IN(mrd), .MEM_ACK_IN(ack), .MEM_REQ_OUT(mreq), .PC_OUT(pc), .VECTOR_TAKEN_OUT(tk),
      .SYS_RESET_OUT(srst), .GATE_OUT(gate));
   cip_mem_model mem (.clk_in(clk), .rst_n_in(rst_n), .req_in(mreq), .erase_in(erase), .rdata_out(mrd),
      .ack_out(ack));
   ////////////////////////////////////////////////////////////////////////
   initial forever #2.5 clk = ~clk;
   // mid-cycle copies give race-free bus samples at the next edge
   always @(negedge clk) {hs, hd} <= {hrdy, hrdata};
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 6000) begin bad_count++; finish_test(); end
   end
   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // one single ahb transfer, waits on hready in both phases
   task ahb(input logic w, input logic [31:0] a, d);
      @(posedge clk); {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
      do @(posedge clk); while (hs !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge clk); while (hs !== 1'b1);
      rd = hd;
   endtask : ahb
   task wait_pc(input logic [15:0] e);
      for (int i = 0; i < 300 && pc !== e; i++) @(negedge clk);
      `CHK("pc", e, pc)
   endtask : wait_pc
   task pulse_reti();
      @(posedge clk) reti <= 1;
      @(posedge clk) reti <= 0;
   endtask : pulse_reti
   ////////////////////////////////////////////////////////////////////////
   task t_boot();
      wait_pc(16'hF8FE);
      ahb(0, 8, 0); `CHK("flags", 32'h1, rd)
      `CHK("gate", 6'h3F, gate)
      `CHK("hresp", 1'b0, hresp)
      $display("boot done");
   endtask : t_boot
   task t_sleep();
      for (int i = 0; i < 7; i++) begin
         if (i == 6) @(posedge clk) osc <= 1;
         ahb(1, 0, (i % 6 == 6 - 4 || i == 6 ? 2 : i % 6) << 4); repeat (3) @(negedge clk);
         `CHK("gate", i == 6 ? 6'h0F : gtab[i], gate)
      end
      @(posedge clk) osc <= 0;
      ahb(1, 0, 0);
      $display("sleep done");
   endtask : t_sleep
   task t_wake();
      ahb(1, 0, 32'h48); @(posedge clk) req <= 12'h003;
      wait_pc(16'hF8E6);
      `CHK("vec_taken", 1'b1, tk)
      `CHK("gate", 6'h3F, gate)
      @(posedge clk) req <= 0; pulse_reti();
      wait_pc(16'hF8FE); @(negedge clk); `CHK("gate", 6'h05, gate)
      ahb(1, 0, 0); @(posedge clk) req <= 12'h800; repeat (30) @(negedge clk);
      `CHK("pc", 16'hF8FE, pc)
      @(posedge clk) req <= 0;
      $display("wake done");
   endtask : t_wake
   task t_nmi();
      ahb(1, 4, 2); @(posedge clk) nmi <= 1; @(posedge clk) nmi <= 0; repeat (20) @(negedge clk);
      `CHK("pc", 16'hF8FE, pc)
      @(posedge clk) oscf <= 1; @(posedge clk) oscf <= 0;
      wait_pc(16'hF8FC);
      pulse_reti(); wait_pc(16'hF8FE);
      $display("nmi done");
   endtask : t_nmi
   task t_reset();
      ahb(1, 8, 32'h7F);
      for (int i = 0; i < 4; i++) begin
         // park pc at zero first, so the reload from the reset vector is seen
         @(posedge clk) rop <= {1'b1, 1'b0, 4'h4, 4'h0};
         @(posedge clk) begin
            rop <= '0;
            if (i < 3) rsrc[i] <= 1;
            else fetch <= {1'b1, 16'h0100};
         end
         @(posedge clk) {rsrc, fetch} <= '0;
         for (int j = 0; j < 4 && srst !== 1'b1; j++) @(negedge clk);
         `CHK("sys_reset", 1'b1, srst)
         wait_pc(16'hF8FE);
      end
      ahb(0, 8, 0); `CHK("flags", 3'h7, rd[3:1])
      // erased reset vector: core must park in the deepest sleep level
      @(posedge clk) {erase, rsrc[0]} <= 2'h3;
      @(posedge clk) rsrc[0] <= 0;
      repeat (20) @(negedge clk);
      `CHK("erased gate", 6'h00, gate)
      @(posedge clk) {erase, rsrc[0]} <= 2'h1;
      @(posedge clk) rsrc[0] <= 0;
      repeat (20) @(negedge clk);
      `CHK("gate", 6'h3F, gate)
      $display("reset done");
   endtask : t_reset
   task t_regop();
      // r5 takes pc, then pc adds r5 on the very next cycle
      @(posedge clk) rop <= {1'b1, 1'b0, 4'h0, 4'h5};
      @(posedge clk) rop <= {1'b1, 1'b1, 4'h5, 4'h0};
      @(posedge clk) rop <= '0; @(negedge clk);
      `CHK("pc", 16'hF1FC, pc)
      @(posedge clk) rop <= {1'b1, 1'b0, 4'h3, 4'h0};
      @(posedge clk) rop <= '0; @(negedge clk);
      `CHK("pc", 16'h0000, pc)
      $display("regop done");
   endtask : t_regop
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      t_boot(); t_sleep(); t_wake(); t_nmi(); t_reset(); t_regop();
      finish_test();
   end
endmodule : test_cpu_interrupt_power_control
